/* File: hw/cfg_load_cfg.svh */
// timing figures and fixed counts of the configuration load link
`ifndef CFG_LOAD_CFG_SVH
`define CFG_LOAD_CFG_SVH
`define CLK_NS 40
`define CYC_UP(ns) (((ns) + `CLK_NS - 1) / `CLK_NS)
`define CYC_DN(ns) ((ns) / `CLK_NS)
// link times in ns
`define T_CF2CD_MAX_NS 1440
`define T_CF2ST0_MAX_NS 960
`define T_CFG_MIN_NS 2000
`define T_STATUS_MIN_NS 268000
`define T_ST2CK_MIN_NS 10000
`define T_CF2CK_MIN_NS 3010000
`define T_CD2UM_MIN_NS 175000
`define T_CONFIG_CLOCK_MAX_NS 10
// cycle counts derived from the times, and the fixed period and edge counts
`define CFG_CYC `CYC_UP(`T_CFG_MIN_NS)
`define STATUS_MIN_CYC `CYC_UP(`T_STATUS_MIN_NS)
`define ST2CK_CYC `CYC_UP(`T_ST2CK_MIN_NS)
`define CF2CK_CYC `CYC_UP(`T_CF2CK_MIN_NS)
`define INIT_MIN_CYC `CYC_UP(`T_CD2UM_MIN_NS)
`define CD2CU_PERIODS 4
`define CD2CU_CYC `CYC_UP(`CD2CU_PERIODS * `T_CONFIG_CLOCK_MAX_NS)
`define UCLK_INIT_EDGES 600
// stream shape
`define LOAD_WORDS 16
`define CMD_BITS 8
`define READ_CMD 8'h03
`define HOST_HALF 4
// active serial half periods for settings 12.5/25/50/100
`define HALF_SET0 6'h20
`define HALF_SET1 6'h10
`define HALF_SET2 6'h08
`define HALF_SET3 6'h04
`endif

/* File: hw/cfg_load_pkg.sv */
// types and shared decoding of the configuration load link
package cfg_load_pkg;
  typedef enum logic [1:0] {
    BUS_W8 = 2'h0,
    BUS_W16 = 2'h1,
    BUS_W32 = 2'h2
  } bus_width_e;

  typedef enum logic [2:0] {
    ST_USER = 3'h0,
    ST_HOLD = 3'h1,
    ST_RELEASE = 3'h2,
    ST_LOAD = 3'h3,
    ST_INIT = 3'h4,
    ST_UCLK = 3'h5,
    ST_FAULT = 3'h6
  } dev_state_e;

  typedef enum logic [2:0] {
    H_IDLE = 3'h0,
    H_PULSE = 3'h1,
    H_WAIT = 3'h2,
    H_GAP = 3'h3,
    H_SEND = 3'h4
  } host_state_e;

  // clocks per data word; encryption and compression never together
  function automatic logic [3:0] clk_ratio(input logic [1:0] w,
                                           input logic enc,
                                           input logic cmp);
    logic [3:0] r;
    r = 4'h1;
    if (cmp) begin
      r = (w == BUS_W8) ? 4'h2 : (w == BUS_W16) ? 4'h4 : 4'h8;
    end else if (enc) begin
      r = (w == BUS_W8) ? 4'h1 : (w == BUS_W16) ? 4'h2 : 4'h4;
    end
    return r;
  endfunction
endpackage

/* File: hw/cfg_link_if.sv */
// configuration link pins between loading host and device
`timescale 1ns/1ns
interface cfg_link_if;
  logic req_n;
  logic host_clk;
  logic host_clk_oe_n;
  logic dev_clk;
  logic dev_clk_oe_n;
  logic health_val;
  logic health_oe_n;
  logic done_val;
  logic done_oe_n;
  logic [31:0] data;
  logic serial_config_out;
  logic serial_in;
  // resolved wire levels, open drain lines pulled high
  wire config_clock = !dev_clk_oe_n ? dev_clk :
                      (!host_clk_oe_n ? host_clk : 1'b0);
  wire config_health_n = health_oe_n ? 1'b1 : health_val;
  wire load_done = done_oe_n ? 1'b1 : done_val;

  modport dev (
    input req_n, config_clock, config_health_n, data, serial_in,
    output dev_clk, dev_clk_oe_n, health_val, health_oe_n,
    output done_val, done_oe_n, serial_config_out
  );
  modport host (
    input config_clock, config_health_n, load_done, serial_config_out,
    output req_n, host_clk, host_clk_oe_n, data, serial_in
  );
endinterface

/* File: hw/cfg_device.sv */
// device end: request/status handshake, loading and initialization
// Contract
// - host holds request low at least 2 us
// - load-complete low within 1440 ns of request
// - status low within 960 ns of request
// - status low between 268 and 3000 us
// - status released within 3000 us of request
// - monitoring host waits 10 us after status
// - blind host waits 3010 us after request
// - parallel clock no faster than 100 MHz
// - data held N-1 clocks after capture
// - oscillator init: user mode 175-830 us
// - user clock: 4 periods, then 600 edges
// - serial launch and sample on falling edge
// - serial clock settings below 12.5/25/50/100
// - multi-device never uses 100 MHz setting
// - host clock is ratio times word rate
// - ratio table by width and feature
`timescale 1ns/1ns
`include "cfg_load_cfg.svh"
module cfg_device #(
  parameter int STATUS_MIN_CYC = `STATUS_MIN_CYC,
  parameter int INIT_MIN_CYC = `INIT_MIN_CYC
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // link
  cfg_link_if.dev link,
  // straps
  input wire logic scheme_i,
  input wire logic [1:0] width_sel_i,
  input wire logic encrypt_i,
  input wire logic compress_i,
  input wire logic user_clk_opt_i,
  input wire logic user_init_clock_i,
  input wire logic multi_device_i,
  input wire logic [1:0] clk_setting_i,
  // loaded words
  output logic [31:0] word_o,
  output logic word_valid_o,
  input wire logic word_ready_i,
  // state
  output logic user_mode_o,
  output logic fault_o
);
  // ------------------------------------------------------------
  // pin synchronisers
  // ------------------------------------------------------------
  logic [36:0] s1_q;
  logic [36:0] s2_q;
  logic ck_prev_q;
  logic uck_prev_q;
  // only the second stage is read; first stage feeds it alone
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      s1_q <= 37'h10_0000_0000;
      s2_q <= 37'h10_0000_0000;
      ck_prev_q <= 1'b0;
      uck_prev_q <= 1'b0;
    end else begin
      s1_q <= {link.req_n, link.config_clock, link.config_health_n,
               user_init_clock_i, link.serial_in, link.data};
      s2_q <= s1_q;
      ck_prev_q <= s2_q[35];
      uck_prev_q <= s2_q[33];
    end
  end

  wire req_s = s2_q[36];
  wire health_s = s2_q[34];
  wire sin_s = s2_q[32];
  wire [31:0] data_s = s2_q[31:0];
  wire config_clock_rise = s2_q[35] & !ck_prev_q;
  wire uck_rise = s2_q[33] & !uck_prev_q;

  // ------------------------------------------------------------
  // state, timer and strap latch
  // ------------------------------------------------------------
  cfg_load_pkg::dev_state_e state_q;
  cfg_load_pkg::dev_state_e state_d;
  logic [16:0] timer_q;
  logic [15:0] cnt_q;
  logic scheme_q;
  logic uopt_q;
  logic [3:0] ratio_q;
  logic [5:0] half_q;
  logic overrun;
  logic push;
  wire chg = state_d != state_q;
  wire in_load = state_q == cfg_load_pkg::ST_LOAD;
  wire [1:0] set_eff = (multi_device_i && clk_setting_i == 2'h3) ?
                       2'h2 : clk_setting_i;
  // every setting runs below its nominal rate
  wire [5:0] half_sel = (set_eff == 2'h0) ? `HALF_SET0 :
                        (set_eff == 2'h1) ? `HALF_SET1 :
                        (set_eff == 2'h2) ? `HALF_SET2 :
                        `HALF_SET3;
  wire init_done = uopt_q ? (timer_q >= 17'(`CD2CU_CYC))
                          : (timer_q >= 17'(INIT_MIN_CYC));

  // next state; a low request restarts from any state
  always_comb begin
    state_d = state_q;
    case (state_q)
      cfg_load_pkg::ST_HOLD: begin
        if (req_s && timer_q >= 17'(STATUS_MIN_CYC)) begin
          state_d = cfg_load_pkg::ST_RELEASE;
        end
      end
      cfg_load_pkg::ST_RELEASE: begin
        if (health_s) begin
          state_d = cfg_load_pkg::ST_LOAD;
        end
      end
      cfg_load_pkg::ST_LOAD: begin
        if (overrun) begin
          state_d = cfg_load_pkg::ST_FAULT;
        end else if (cnt_q == 16'(`LOAD_WORDS)) begin
          state_d = cfg_load_pkg::ST_INIT;
        end
      end
      cfg_load_pkg::ST_INIT: begin
        if (init_done) begin
          state_d = uopt_q ? cfg_load_pkg::ST_UCLK
                           : cfg_load_pkg::ST_USER;
        end
      end
      cfg_load_pkg::ST_UCLK: begin
        if (cnt_q == 16'(`UCLK_INIT_EDGES)) begin
          state_d = cfg_load_pkg::ST_USER;
        end
      end
      default: begin
      end
    endcase
    if (!req_s) begin
      state_d = cfg_load_pkg::ST_HOLD;
    end
  end

  // state and shared timer; power-up behaves as a request
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state_q <= cfg_load_pkg::ST_HOLD;
      timer_q <= 17'h0;
    end else begin
      state_q <= state_d;
      timer_q <= chg ? 17'h0 : (timer_q + {16'h0, !(&timer_q)});
    end
  end

  // counts words while loading and user clock edges while waiting
  always_ff @(posedge clock_i) begin
    if (!resetn_i || chg) begin
      cnt_q <= 16'h0;
    end else if (push || (state_q == cfg_load_pkg::ST_UCLK &&
                          uck_rise)) begin
      cnt_q <= cnt_q + 16'h1;
    end
  end

  // straps are taken while the request holds the device in reset
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      scheme_q <= 1'b0;
      uopt_q <= 1'b0;
      ratio_q <= 4'h1;
      half_q <= `HALF_SET0;
    end else if (state_q == cfg_load_pkg::ST_HOLD) begin
      scheme_q <= scheme_i;
      uopt_q <= user_clk_opt_i;
      ratio_q <= cfg_load_pkg::clk_ratio(width_sel_i, encrypt_i,
                                         compress_i);
      half_q <= half_sel;
    end
  end

  // ------------------------------------------------------------
  // passive parallel capture
  // ------------------------------------------------------------
  logic [3:0] rcnt_q;
  // first rise of each ratio group captures; host holds the rest
  wire pp_cap = in_load & !scheme_q & config_clock_rise & (rcnt_q == 4'h0);
  always_ff @(posedge clock_i) begin
    if (!resetn_i || !in_load) begin
      rcnt_q <= 4'h0;
    end else if (config_clock_rise && !scheme_q) begin
      rcnt_q <= (rcnt_q == ratio_q - 4'h1) ? 4'h0 : rcnt_q + 4'h1;
    end
  end

  // ------------------------------------------------------------
  // active serial clock and shifters
  // ------------------------------------------------------------
  logic [5:0] div_q;
  logic ck_q;
  logic [3:0] fidx_q;
  logic [7:0] sr_q;
  logic sout_q;
  logic [6:0] inb_q;
  logic [2:0] bcnt_q;
  logic buf_ready;
  // the clock stops while the buffer is full, so no bit is lost
  wire as_run = in_load & scheme_q & buf_ready;
  wire as_tog = as_run & (div_q == half_q - 6'h1);
  wire as_fall = as_tog & ck_q;
  wire sample = as_fall & (fidx_q == 4'(`CMD_BITS));
  wire as_push = sample & (bcnt_q == 3'h7);

  always_ff @(posedge clock_i) begin
    if (!resetn_i || !in_load) begin
      div_q <= 6'h0;
      ck_q <= 1'b0;
      fidx_q <= 4'h0;
    end else if (as_run) begin
      div_q <= as_tog ? 6'h0 : div_q + 6'h1;
      ck_q <= as_tog ? !ck_q : ck_q;
      if (as_fall && fidx_q != 4'(`CMD_BITS)) begin
        fidx_q <= fidx_q + 4'h1;
      end
    end
  end

  // read command leaves on falling edges, data taken on falling edges
  always_ff @(posedge clock_i) begin
    if (!resetn_i || !in_load) begin
      sr_q <= `READ_CMD;
      sout_q <= 1'b0;
      inb_q <= 7'h0;
      bcnt_q <= 3'h0;
    end else begin
      if (as_fall) begin
        sout_q <= sr_q[7];
        sr_q <= {sr_q[6:0], 1'b0};
      end
      if (sample) begin
        inb_q <= {inb_q[5:0], sin_s};
        bcnt_q <= bcnt_q + 3'h1;
      end
    end
  end

  // ------------------------------------------------------------
  // two-entry word buffer
  // ------------------------------------------------------------
  logic [31:0] slot0_q;
  logic [31:0] slot1_q;
  logic v0_q;
  logic v1_q;
  assign push = pp_cap | as_push;
  assign buf_ready = !v1_q;
  // parallel data cannot be stalled, so a full buffer is a fault
  assign overrun = pp_cap & !buf_ready;
  wire [31:0] push_word = scheme_q ? {24'h0, inb_q, sin_s} : data_s;
  wire pop = v0_q & word_ready_i;
  wire push_ok = push & buf_ready;

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      v0_q <= 1'b0;
      v1_q <= 1'b0;
    end else begin
      v0_q <= v1_q | push_ok | (v0_q & !pop);
      v1_q <= pop ? 1'b0 : (v1_q | (push_ok & v0_q));
    end
  end

  always_ff @(posedge clock_i) begin
    if (pop || !v0_q) begin
      slot0_q <= (pop && v1_q) ? slot1_q : push_word;
    end
    if (push_ok && v0_q && !pop) begin
      slot1_q <= push_word;
    end
  end

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  logic health_oe_n_q;
  logic done_oe_n_q;
  logic config_clock_oe_n_q;
  logic user_mode_q;
  logic fault_q;
  wire hold_d = state_d == cfg_load_pkg::ST_HOLD;
  wire fault_d = state_d == cfg_load_pkg::ST_FAULT;
  wire busy_d = hold_d || state_d == cfg_load_pkg::ST_RELEASE ||
                state_d == cfg_load_pkg::ST_LOAD;
  // status and load-complete fall three cycles after the request
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      health_oe_n_q <= 1'b0;
      done_oe_n_q <= 1'b0;
      config_clock_oe_n_q <= 1'b1;
      user_mode_q <= 1'b0;
      fault_q <= 1'b0;
    end else begin
      health_oe_n_q <= !(hold_d || fault_d);
      done_oe_n_q <= !(busy_d || fault_d);
      config_clock_oe_n_q <= !scheme_q;
      user_mode_q <= state_d == cfg_load_pkg::ST_USER;
      fault_q <= fault_d;
    end
  end

  assign link.health_val = 1'b0;
  assign link.done_val = 1'b0;
  assign link.health_oe_n = health_oe_n_q;
  assign link.done_oe_n = done_oe_n_q;
  assign link.dev_clk = ck_q;
  assign link.dev_clk_oe_n = config_clock_oe_n_q;
  assign link.serial_config_out = sout_q;
  assign word_o = slot0_q;
  assign word_valid_o = v0_q;
  assign user_mode_o = user_mode_q;
  assign fault_o = fault_q;
endmodule

/* File: hw/cfg_host.sv */
// host end: request pulse, waits, and word delivery to the device
`timescale 1ns/1ns
`include "cfg_load_cfg.svh"
module cfg_host #(
  parameter int CF2CK_CYC = `CF2CK_CYC
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // link
  cfg_link_if.host link,
  // control
  input wire logic start_i,
  input wire logic monitor_i,
  input wire logic scheme_i,
  input wire logic [1:0] width_sel_i,
  input wire logic encrypt_i,
  input wire logic compress_i,
  // words to load
  input wire logic [31:0] word_i,
  input wire logic word_valid_i,
  output logic word_ready_o,
  // state
  output logic busy_o,
  output logic loaded_o,
  output logic health_o
);
  // ------------------------------------------------------------
  // synchronisers for device-driven lines
  // ------------------------------------------------------------
  logic [2:0] s1_q;
  logic [2:0] s2_q;
  logic dck_prev_q;
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      s1_q <= 3'h0;
      s2_q <= 3'h0;
      dck_prev_q <= 1'b0;
    end else begin
      s1_q <= {link.config_health_n, link.load_done, link.config_clock};
      s2_q <= s1_q;
      dck_prev_q <= s2_q[0];
    end
  end
  wire health_s = s2_q[2];
  wire done_s = s2_q[1];
  wire dck_fall = dck_prev_q & !s2_q[0];

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  cfg_load_pkg::host_state_e state_q;
  cfg_load_pkg::host_state_e state_d;
  logic [16:0] timer_q;
  logic scheme_q;
  logic [3:0] ratio_q;
  wire send = state_q == cfg_load_pkg::H_SEND;

  always_comb begin
    state_d = state_q;
    case (state_q)
      cfg_load_pkg::H_IDLE: begin
        if (start_i) begin
          state_d = cfg_load_pkg::H_PULSE;
        end
      end
      cfg_load_pkg::H_PULSE: begin
        if (timer_q >= 17'(`CFG_CYC)) begin
          state_d = cfg_load_pkg::H_WAIT;
        end
      end
      cfg_load_pkg::H_WAIT: begin
        // the device clocks a serial load itself, so follow it at once
        if (scheme_q && health_s) begin
          state_d = cfg_load_pkg::H_SEND;
        end else if (monitor_i && health_s) begin
          state_d = cfg_load_pkg::H_GAP;
        end else if (!monitor_i && timer_q >= 17'(CF2CK_CYC)) begin
          state_d = cfg_load_pkg::H_SEND;
        end
      end
      cfg_load_pkg::H_GAP: begin
        if (timer_q >= 17'(`ST2CK_CYC)) begin
          state_d = cfg_load_pkg::H_SEND;
        end
      end
      cfg_load_pkg::H_SEND: begin
        if (done_s || !health_s) begin
          state_d = cfg_load_pkg::H_IDLE;
        end
      end
      default: begin
        state_d = cfg_load_pkg::H_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      state_q <= cfg_load_pkg::H_IDLE;
      timer_q <= 17'h0;
    end else begin
      state_q <= state_d;
      timer_q <= (state_d != state_q) ? 17'h0
               : (timer_q + {16'h0, !(&timer_q)});
    end
  end

  // mode is fixed for the whole load at the start request
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      scheme_q <= 1'b0;
      ratio_q <= 4'h1;
    end else if (state_q == cfg_load_pkg::H_IDLE && start_i) begin
      scheme_q <= scheme_i;
      ratio_q <= cfg_load_pkg::clk_ratio(width_sel_i, encrypt_i,
                                         compress_i);
    end
  end

  // ------------------------------------------------------------
  // word delivery
  // ------------------------------------------------------------
  logic [31:0] data_q;
  logic have_q;
  logic ready_q;
  logic [2:0] div_q;
  logic ck_q;
  logic [3:0] per_q;
  logic [3:0] hf_q;
  logic [2:0] bit_q;
  logic sin_q;
  wire take = ready_q & word_valid_i;
  // parallel clock: half period of four cycles, 3.125 MHz
  wire pp_run = send & !scheme_q & have_q;
  wire tog = pp_run & (div_q == 3'(`HOST_HALF - 1));
  wire rise = tog & !ck_q;
  wire pp_end = tog & ck_q & (per_q == ratio_q);
  // serial: first bit leaves on the last command falling edge
  wire launch = send & scheme_q & dck_fall &
                (hf_q >= 4'(`CMD_BITS - 1)) & have_q;
  wire as_end = launch & (bit_q == 3'h7);
  wire have_d = take | (have_q & !(pp_end | as_end));

  always_ff @(posedge clock_i) begin
    if (!resetn_i || !send) begin
      have_q <= 1'b0;
      div_q <= 3'h0;
      ck_q <= 1'b0;
      per_q <= 4'h0;
      hf_q <= 4'h0;
      bit_q <= 3'h0;
    end else begin
      have_q <= have_d;
      div_q <= !pp_run ? 3'h0 : (tog ? 3'h0 : div_q + 3'h1);
      ck_q <= tog ? !ck_q : ck_q;
      per_q <= take ? 4'h0 : (rise ? per_q + 4'h1 : per_q);
      if (dck_fall && hf_q != 4'(`CMD_BITS)) begin
        hf_q <= hf_q + 4'h1;
      end
      bit_q <= launch ? bit_q + 3'h1 : bit_q;
    end
  end

  // word held on the data pins until its last ratio period ends; when serial, its low byte shifts out at each launch
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      data_q <= 32'h0;
      sin_q <= 1'b0;
    end else if (take) begin
      data_q <= word_i;
    end else if (launch) begin
      sin_q <= data_q[7];
      data_q <= {data_q[31:8], data_q[6:0], 1'b0};
    end
  end

  // ------------------------------------------------------------
  // registered outputs
  // ------------------------------------------------------------
  logic req_n_q;
  logic clk_oe_n_q;
  logic busy_q;
  logic loaded_q;
  logic health_q;
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      ready_q <= 1'b0;
      req_n_q <= 1'b1;
      clk_oe_n_q <= 1'b1;
      busy_q <= 1'b0;
      loaded_q <= 1'b0;
      health_q <= 1'b0;
    end else begin
      ready_q <= (state_d == cfg_load_pkg::H_SEND) & !have_d;
      req_n_q <= state_d != cfg_load_pkg::H_PULSE;
      clk_oe_n_q <= scheme_q;
      busy_q <= state_d != cfg_load_pkg::H_IDLE;
      if (start_i && state_q == cfg_load_pkg::H_IDLE) begin
        loaded_q <= 1'b0;
      end else if (send && done_s) begin
        loaded_q <= 1'b1;
      end
      health_q <= health_s;
    end
  end

  assign link.req_n = req_n_q;
  assign link.host_clk = ck_q;
  assign link.host_clk_oe_n = clk_oe_n_q;
  assign link.data = data_q;
  assign link.serial_in = sin_q;
  assign word_ready_o = ready_q;
  assign busy_o = busy_q;
  assign loaded_o = loaded_q;
  assign health_o = health_q;
endmodule

/* File: test/cfg_load_asserts.sv */
// concurrent checks on the configuration link between host and device
`timescale 1ns/1ns
module cfg_load_asserts #(
  parameter int STATUS_MIN_CYC = 100
) (
  // clock and reset
  input wire logic clock_i,
  input wire logic resetn_i,
  // link
  input wire logic req_n,
  input wire logic config_clock,
  input wire logic dev_clk_oe_n,
  input wire logic config_health_n,
  input wire logic load_done,
  input wire logic serial_config_out,
  input wire logic [31:0] data
);
  default clocking dck @(posedge clock_i); endclocking
  default disable iff (!resetn_i);
  // ---------------
  // helper counters
  // ---------------
  // all but hl_rel_q saturate, so a long stall never wraps into a false pass
  logic [17:0] req_lo_q, hl_lo_q, hl_rel_q, hl_hi_q, run_q;
  logic clk_q;
  always_ff @(posedge clock_i) begin
    if (!resetn_i) begin
      {req_lo_q, hl_lo_q, hl_rel_q, hl_hi_q, run_q, clk_q} <= '0;
    end else begin
      req_lo_q <= req_n ? '0 : req_lo_q + {17'h0, ~&req_lo_q};
      hl_lo_q <= config_health_n ? '0 : hl_lo_q + {17'h0, ~&hl_lo_q};
      hl_rel_q <= (config_health_n || !req_n) ? '0 : hl_rel_q + 18'h1;
      hl_hi_q <= config_health_n ? hl_hi_q + {17'h0, ~&hl_hi_q} : '0;
      run_q <= (config_clock != clk_q) ? '0 : run_q + {17'h0, ~&run_q};
      clk_q <= config_clock;
    end
  end
  // ----------
  // assertions
  // ----------
  AST_REQ_WIDTH: assert property (
    $rose(req_n) |-> req_lo_q >= 18'd50) else $error("request too short");
  AST_DONE_LOW: assert property (
    $fell(req_n) |-> ##[1:36] !load_done) else $error("done not low");
  AST_HEALTH_LOW: assert property (
    $fell(req_n) |-> ##[1:24] !config_health_n) else $error("status late");
  AST_HEALTH_MIN: assert property (
    $rose(config_health_n) |-> hl_lo_q >= STATUS_MIN_CYC)
    else $error("status low too short");
  AST_HEALTH_REL: assert property (
    hl_rel_q <= 18'd75000) else $error("status not released");
  AST_CLK_AFTER_HEALTH: assert property (
    $rose(config_clock) && dev_clk_oe_n |-> hl_hi_q >= 18'd250)
    else $error("clock too soon after status");
  AST_DATA_HOLD: assert property (
    $changed(data) && dev_clk_oe_n |-> !config_clock)
    else $error("data moved while clock high");
  AST_SER_LAUNCH: assert property (
    !dev_clk_oe_n && config_clock && $past(config_clock)
    |-> $stable(serial_config_out)) else $error("serial out off fall");
  AST_AS_RATE: assert property (
    $changed(config_clock) && !dev_clk_oe_n && !$past(dev_clk_oe_n)
    |-> run_q >= 18'd3) else $error("serial clock too fast");
  AST_DONE_HEALTH: assert property (
    $rose(load_done) |-> config_health_n) else $error("done during fault");
  // main scenarios reached
  cover property ($rose(load_done));
  cover property (!dev_clk_oe_n && $fell(config_clock));
  cover property ($rose(config_health_n));
endmodule

/* File: test/fpp_as_config_sequencing_tb.sv */
// self-checking bench joining host and device across the link
`timescale 1ns/1ns
`include "cfg_load_cfg.svh"
module fpp_as_config_sequencing_tb;
  logic clock_i = 1'b0, resetn_i = 1'b0, start_i = 1'b0, monitor_i = 1'b0;
  logic scheme_i = 1'b0, encrypt_i = 1'b0, compress_i = 1'b0;
  logic user_clk_opt_i = 1'b0, user_init_clock_i = 1'b0;
  logic multi_device_i = 1'b0, word_valid_i = 1'b0, word_ready_i = 1'b0;
  logic [1:0] width_sel_i = 2'h0, clk_setting_i = 2'h0;
  logic [31:0] word_i = 32'h0, word_o;
  logic word_valid_o, word_ready_o, busy_o, loaded_o, health_o;
  logic user_mode_o, fault_o, tk = 1'b0, cq = 1'b0;
  logic [7:0] sh = 8'h0;
  logic [31:0] wq [16];
  logic [31:0] eq [$];
  int fi = 16, rises = 0, hi = 0, first = 0, seen = 0, um = 0;
  int n_mismatch = 0, comparisons = 0;
  always #20 clock_i = ~clock_i;
  always #80 user_init_clock_i = ~user_init_clock_i;
  cfg_link_if link();
  cfg_host #(.CF2CK_CYC(400)) u_cfg_host (
    .clock_i(clock_i), .resetn_i(resetn_i), .link(link),
    .start_i(start_i), .monitor_i(monitor_i), .scheme_i(scheme_i),
    .width_sel_i(width_sel_i), .encrypt_i(encrypt_i),
    .compress_i(compress_i), .word_i(word_i), .word_valid_i(word_valid_i),
    .word_ready_o(word_ready_o), .busy_o(busy_o), .loaded_o(loaded_o),
    .health_o(health_o));
  cfg_device #(.STATUS_MIN_CYC(100), .INIT_MIN_CYC(100)) u_cfg_device (
    .clock_i(clock_i), .resetn_i(resetn_i), .link(link),
    .scheme_i(scheme_i), .width_sel_i(width_sel_i), .encrypt_i(encrypt_i),
    .compress_i(compress_i), .user_clk_opt_i(user_clk_opt_i),
    .user_init_clock_i(user_init_clock_i),
    .multi_device_i(multi_device_i), .clk_setting_i(clk_setting_i),
    .word_o(word_o), .word_valid_o(word_valid_o),
    .word_ready_i(word_ready_i), .user_mode_o(user_mode_o),
    .fault_o(fault_o));
  cfg_load_asserts #(.STATUS_MIN_CYC(100)) u_cfg_load_asserts (
    .clock_i(clock_i), .resetn_i(resetn_i), .req_n(link.req_n),
    .config_clock(link.config_clock), .dev_clk_oe_n(link.dev_clk_oe_n),
    .config_health_n(link.config_health_n), .load_done(link.load_done),
    .serial_config_out(link.serial_config_out), .data(link.data));
  // -----------------
  // compare and close
  // -----------------
  task automatic check(input string nm, input logic [31:0] got, exp);
    comparisons++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", nm, exp, got);
    end
  endtask
  task automatic wrap_up();
    $display("comparisons %0d n_mismatch %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // observe the stream and the link; outputs read before the edge lands
  always @(posedge clock_i) begin
    tk = word_valid_i && word_ready_o;
    if (word_valid_o && word_ready_i) check("word_o", word_o, eq.pop_front());
    if (link.config_clock && !cq) begin
      rises++;
      sh = {sh[6:0], link.serial_config_out};
      if (sh == `READ_CMD) seen = 1;
    end
    if (link.config_clock) hi++;
    else begin
      if (cq && first == 0) first = hi;
      hi = 0;
    end
    if (!link.load_done) um = 0;
    else if (!user_mode_o) um++;
    cq = link.config_clock;
  end
  // feed words to the host, stall the word sink one cycle in four
  always @(negedge clock_i) begin
    if (tk) fi++;
    word_valid_i <= fi < 16;
    word_i <= wq[fi % 16];
    word_ready_i <= ($urandom % 4) != 0;
  end
  // one whole load; k picks width and feature, or the serial setting
  task automatic run(input int s, input int k);
    int n, rt, hx;
    @(negedge clock_i);
    scheme_i = s[0];
    width_sel_i = 2'(k / 3);
    encrypt_i = !s && k % 3 == 1;
    compress_i = !s && k % 3 == 2;
    clk_setting_i = (k == 4) ? 2'h3 : 2'(k);
    multi_device_i = s && k == 4;
    user_clk_opt_i = s && k == 4;
    monitor_i = k[0];
    rt = (k % 3 == 0) ? 1 : 1 << (k / 3 + k % 3 - 1);
    hx = (k == 4) ? 8 : 32 >> k;
    for (int i = 0; i < 16; i++) begin
      wq[i] = $urandom;
      eq.push_back(s ? {24'h0, wq[i][7:0]} : wq[i]);
    end
    rises = 0;
    first = 0;
    seen = 0;
    fi = 0;
    start_i = 1'b1;
    @(negedge clock_i);
    start_i = 1'b0;
    for (n = 0; n < 30000 && (eq.size() > 0 || !user_mode_o); n++) begin
      @(negedge clock_i);
    end
    if (n == 30000) begin
      n_mismatch++;
      wrap_up();
    end
    if (!s) check("rises", rises > 15 * rt && rises <= 16 * rt, 1);
    if (s) check("half period", first, hx);
    if (s) check("command", seen, 1);
    if (s && k == 4) check("user clk init", um > 2390 && um < 2410, 1);
    else check("osc init", um >= 100 && um <= 474, 1);
    check("fault_o", fault_o, 1'b0);
    check("host idle", {busy_o, loaded_o, health_o}, 3'b011);
  endtask
  initial begin
    void'($urandom(53632));
    repeat (4) @(negedge clock_i);
    resetn_i = 1'b1;
    for (int k = 0; k < 9; k++) run(0, k);
    for (int k = 0; k < 5; k++) run(1, k);
    wrap_up();
  end
endmodule
